//--- src/spsr_top.sv
`include "spsr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module spsr_top (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Host control pins
    input wire logic chip_sel_n_in,
    input wire logic read_write_in,
    input wire logic shift_clock_fall_in,
    input wire logic store_clock_in,
    input wire logic store_clear_n_in,
    // Serial pin
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_oe_out,
    // Parallel outputs
    output logic [`SPSR_WIDTH-1:0] parallel_out,
    // Mode status
    output logic [1:0] mode_out
);
    localparam int W = `SPSR_WIDTH;
    spsr_pkg::spsr_mode_t mode;
    logic [W-1:0] shift_reg, shift_next;
    logic [W-1:0] store_reg, store_next;
    logic shclk_reg, stclk_reg;
    logic serial_out_reg, serial_out_next, oe_reg, oe_next;
    logic [1:0] mode_reg;
    logic shift_fall, store_rise;

    // Stored words are also pushed into the FIFO, whose output is drained and unused
    spsr_stream_if #(.WIDTH(W)) fin ();
    spsr_stream_if #(.WIDTH(W)) fout ();

    spsr_fifo #(.WIDTH(W), .DEPTH(`SPSR_FIFO_DEPTH)) u_fifo (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .wr(fin),
        .rd(fout)
    );

    assign shift_fall = shclk_reg && !shift_clock_fall_in;
    assign store_rise = !stclk_reg && store_clock_in;

    always_comb begin
        if (chip_sel_n_in) begin
            mode = spsr_pkg::SPSR_HOLD;
        end else if (!read_write_in) begin
            mode = spsr_pkg::SPSR_SER_LOAD;
        end else if (store_clock_in) begin
            mode = spsr_pkg::SPSR_PAR_LOAD;
        end else begin
            mode = spsr_pkg::SPSR_SER_OUT;
        end
    end

    always_comb begin
        shift_next = shift_reg;
        serial_out_next = serial_out_reg;
        oe_next = (mode == spsr_pkg::SPSR_SER_OUT);
        if (shift_fall) begin
            unique case (mode)
                spsr_pkg::SPSR_HOLD: shift_next = shift_reg;
                spsr_pkg::SPSR_SER_LOAD: shift_next = {serial_in, shift_reg[W-1:1]};
                spsr_pkg::SPSR_SER_OUT: begin
                    shift_next = {shift_reg[0], shift_reg[W-1:1]};
                    serial_out_next = shift_reg[0];
                end
                spsr_pkg::SPSR_PAR_LOAD: shift_next = store_reg;
            endcase
        end
    end

    always_comb begin
        store_next = store_reg;
        if (!chip_sel_n_in && !read_write_in && store_rise) begin
            store_next = shift_reg;
        end
        fin.valid = store_rise && !chip_sel_n_in && !read_write_in;
        fin.data = shift_reg;
        fout.ready = 1'b1;
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            shift_reg <= `SPSR_SHIFT_RST;
            shclk_reg <= 1'b0;
            stclk_reg <= 1'b0;
            serial_out_reg <= 1'b0;
            oe_reg <= 1'b0;
            mode_reg <= 2'h0;
        end else begin
            shift_reg <= shift_next;
            shclk_reg <= shift_clock_fall_in;
            stclk_reg <= store_clock_in;
            serial_out_reg <= serial_out_next;
            oe_reg <= oe_next;
            mode_reg <= mode;
        end
    end

    // Clear is asynchronous and overrides everything
    always_ff @(posedge clk_sys_in or negedge store_clear_n_in) begin
        if (!store_clear_n_in) begin
            store_reg <= `SPSR_STORE_RST;
        end else if (sys_rst_in) begin
            store_reg <= `SPSR_STORE_RST;
        end else begin
            store_reg <= store_next;
        end
    end

    assign parallel_out = store_reg;
    assign serial_out = serial_out_reg;
    assign serial_oe_out = oe_reg;
    assign mode_out = mode_reg;
endmodule // spsr_top
`default_nettype wire

//--- common/spsr_map.svh
// Function
// - Sixteen-bit shift register plus sixteen-bit storage register driving parallel outputs continuously.
// - One two-way serial pin: data in on load, three-state data out on shift-out.
// - Shift register modes: hold, serial load, recirculating serial out, parallel load.
// - Chip select high ignores shift clock, holds shift register, floats serial pin.
// - Shift register acts only on falling shift clock edge, never on rising edge.
// - Select low, read high, store clock low: fall drives next bit out and recirculates.
// - Select low, read high, store clock high: fall loads shift register from storage.
// - Select and read/write low: store clock rise copies shift register into storage.
// - Storage register holds while chip select or read/write is high.
// - Low store clear empties storage register at once, above every other input.
`ifndef SPSR_MAP_SVH
`define SPSR_MAP_SVH
`define SPSR_WIDTH 16
`define SPSR_FIFO_DEPTH 16
`define SPSR_SHIFT_RST 16'h0000
`define SPSR_STORE_RST 16'h0000
`endif

//--- common/spsr_pkg.sv
package spsr_pkg;
    typedef enum logic [1:0] {
        SPSR_HOLD,
        SPSR_SER_LOAD,
        SPSR_SER_OUT,
        SPSR_PAR_LOAD
    } spsr_mode_t;
endpackage

//--- common/spsr_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spsr_stream_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- src/spsr_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module spsr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Stream sides
    spsr_stream_if.sink wr,
    spsr_stream_if.source rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH)) || rd.ready;
    assign rd.valid = cnt_reg != '0;
    assign rd.data = mem_reg[rptr_reg];

    always_comb begin
        wptr_next = push ? wptr_reg + AW'(1) : wptr_reg;
        rptr_next = pop ? rptr_reg + AW'(1) : rptr_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_reg[wptr_reg] <= wr.data;
        end
    end
endmodule // spsr_fifo
`default_nettype wire

//--- bench/spsr_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module spsr_asserts (
    input wire logic clk_sys_in, sys_rst_in, chip_sel_n_in, read_write_in, shift_clock_fall_in, store_clock_in,
    input wire logic store_clear_n_in, serial_out, serial_oe_out,
    input wire logic [15:0] parallel_out,
    input wire logic [1:0] mode_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    chk_clear_zero: assert property (!store_clear_n_in |-> parallel_out == 16'h0000) else $error("clear");
    chk_cs_float: assert property (chip_sel_n_in [*3] |=> !serial_oe_out) else $error("oe cs");
    chk_cs_noshift: assert property (chip_sel_n_in [*2] |=> $stable(serial_out)) else $error("cs shift");
    chk_mode_idle: assert property (chip_sel_n_in [*2] |=> mode_out == spsr_pkg::SPSR_HOLD) else $error("mode");
    chk_store_hold: assert property ((chip_sel_n_in || read_write_in) [*2]
        |=> !store_clear_n_in || $stable(parallel_out)) else $error("store hold");
    chk_load_quiet: assert property ((!read_write_in) [*3] |=> !serial_oe_out) else $error("oe load");
    chk_rise_idle: assert property (!$fell(shift_clock_fall_in) |=> $stable(serial_out)) else $error("rise");
    chk_par_noshift: assert property ($fell(shift_clock_fall_in) && store_clock_in && read_write_in
        |=> $stable(serial_out)) else $error("par");
endmodule // spsr_asserts
`default_nettype wire

//--- bench/spsr_host.sv
`timescale 1ns/10ps
`default_nettype none
module spsr_host (
    input wire logic clk_sys_in, serial_out, serial_oe_out,
    output logic chip_sel_n_in, read_write_in, shift_clock_fall_in, store_clock_in, store_clear_n_in, serial_in
);
    logic b = 0;
    initial {chip_sel_n_in, read_write_in, shift_clock_fall_in, store_clock_in, store_clear_n_in} = 5'h19;
    // Released pin shows the inverse of the last driven level
    assign serial_in = serial_oe_out ? serial_out : read_write_in ? ~serial_out : b;
    // One clock pulse, shift or store, each level held two cycles
    task automatic pulse(input logic cs, rw, st, sh, d);
        {chip_sel_n_in, read_write_in, b} <= {cs, rw, d};
        for (int k = 1; k >= 0; k--) begin
            {shift_clock_fall_in, store_clock_in} <= sh ? {k[0], st} : {1'b0, k[0]};
            repeat (2) @(posedge clk_sys_in);
        end
    endtask
endmodule // spsr_host
`default_nettype wire

//--- bench/spsr_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module spsr_top_bench;
    logic clk_sys_in = 0, sys_rst_in = 1;
    logic chip_sel_n_in, read_write_in, shift_clock_fall_in, store_clock_in, store_clear_n_in, serial_in;
    logic serial_out, serial_oe_out;
    logic [15:0] parallel_out, seen;
    logic [1:0] mode_out;
    int n_errors = 0, check_count = 0;
    spsr_top u_dut (.*);
    spsr_host u_host (.*);
    initial forever #5 clk_sys_in = ~clk_sys_in;
    task automatic cmp(input string s, input logic [15:0] e, g);
        check_count++;
        if (g !== e) $display("wrong value %s exp %h got %h", s, e, g);
        n_errors += int'(g !== e);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Sixteen shift clocks, loading when rw is low, shifting out when high
    task automatic move(input logic rw, input logic [15:0] v);
        for (int i = 0; i < 16; i++) begin
            u_host.pulse(0, rw, 0, 1, v[i]);
            seen[i] = serial_out;
        end
        cmp("oe", {15'h0, rw}, {15'h0, serial_oe_out});
        cmp("mode", {14'h0, rw ? 2'(spsr_pkg::SPSR_SER_OUT) : 2'(spsr_pkg::SPSR_SER_LOAD)}, {14'h0, mode_out});
        if (rw) cmp("sout", v, seen);
    endtask
    task automatic t_store;
        move(0, 16'hA5C3);
        u_host.pulse(0, 0, 0, 0, 0);
        cmp("store", 16'hA5C3, parallel_out);
        move(1, 16'hA5C3);
        move(1, 16'hA5C3);
    endtask
    task automatic t_hold;
        move(0, 16'h0F0F);
        u_host.pulse(1, 0, 0, 1, 1);
        u_host.pulse(1, 0, 0, 0, 0);
        u_host.pulse(0, 1, 0, 0, 0);
        cmp("hold", 16'hA5C3, parallel_out);
        move(1, 16'h0F0F);
        u_host.pulse(0, 1, 1, 1, 0);
        move(1, 16'hA5C3);
    endtask
    task automatic t_clear;
        u_host.store_clear_n_in <= 0;
        u_host.pulse(0, 0, 0, 0, 0);
        cmp("clear", 16'h0000, parallel_out);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_in);
        sys_rst_in <= 0;
        @(posedge clk_sys_in);
        t_store;
        t_hold;
        t_clear;
        end_sim;
    end
    initial #20000 begin
        n_errors++;
        end_sim;
    end
endmodule // spsr_top_bench
bind spsr_top spsr_asserts u_chk (.*);
`default_nettype wire
